// ==== design/modem_params_pkg.sv ====
package modem_params_pkg;

   // ********************************************************************
   // Clock and timing.
   // ********************************************************************
   localparam int CLK_HZ = 50000000;

   // ********************************************************************
   // Field limits and special values.
   // ********************************************************************
   localparam logic [3:0] SF_MIN          = 4'h6;
   localparam logic [3:0] SF_MAX          = 4'hc;
   localparam logic [3:0] SF_HIGH_RATE    = 4'h6;
   localparam logic [2:0] CR_MIN          = 3'h1;
   localparam logic [2:0] CR_MAX          = 3'h4;
   localparam logic [2:0] CR_HEADER       = 3'h4;
   localparam logic [3:0] OVERHEAD_BASE   = 4'h4;
   localparam logic [3:0] BW_CODE_MAX     = 4'h9;
   localparam logic [3:0] BW_LOW_BAND_MAX = 4'h7;
   localparam logic [2:0] SF6_DETECT_TUNE = 3'h5;
   localparam logic [7:0] SF6_THRESHOLD   = 8'h0c;

   // ********************************************************************
   // Values after reset.
   // ********************************************************************
   localparam logic [3:0] RESET_SF        = 4'h7;
   localparam logic [2:0] RESET_CR        = 3'h1;
   localparam logic [3:0] RESET_BW        = 4'h7;
   localparam logic [2:0] RESET_DETECT    = 3'h3;
   localparam logic [7:0] RESET_THRESHOLD = 8'h0a;

   // ********************************************************************
   // Channel widths in hertz, codes 0 to 9, and cycles per chip.
   // ********************************************************************
   localparam int BW0_HZ = 7800;
   localparam int BW1_HZ = 10400;
   localparam int BW2_HZ = 15600;
   localparam int BW3_HZ = 20800;
   localparam int BW4_HZ = 31200;
   localparam int BW5_HZ = 41700;
   localparam int BW6_HZ = 62500;
   localparam int BW7_HZ = 125000;
   localparam int BW8_HZ = 250000;
   localparam int BW9_HZ = 500000;
   localparam logic [12:0] CHIP_CYC_0 = 13'(CLK_HZ / BW0_HZ);
   localparam logic [12:0] CHIP_CYC_1 = 13'(CLK_HZ / BW1_HZ);
   localparam logic [12:0] CHIP_CYC_2 = 13'(CLK_HZ / BW2_HZ);
   localparam logic [12:0] CHIP_CYC_3 = 13'(CLK_HZ / BW3_HZ);
   localparam logic [12:0] CHIP_CYC_4 = 13'(CLK_HZ / BW4_HZ);
   localparam logic [12:0] CHIP_CYC_5 = 13'(CLK_HZ / BW5_HZ);
   localparam logic [12:0] CHIP_CYC_6 = 13'(CLK_HZ / BW6_HZ);
   localparam logic [12:0] CHIP_CYC_7 = 13'(CLK_HZ / BW7_HZ);
   localparam logic [12:0] CHIP_CYC_8 = 13'(CLK_HZ / BW8_HZ);
   localparam logic [12:0] CHIP_CYC_9 = 13'(CLK_HZ / BW9_HZ);

   // ********************************************************************
   // Types.
   // ********************************************************************
   typedef struct packed {
      logic [3:0] spread_factor_value;
      logic [2:0] cyclic_code_select;
      logic [3:0] bandwidth_code;
      logic       implicit_header;
      logic       crc_on;
      logic [2:0] detect_tuning_field;
      logic [7:0] detect_threshold;
   } modem_cfg_t;

   typedef struct packed {
      logic [7:0] data;
      logic [2:0] code_rate;
      logic       is_header;
   } sym_word_t;

   typedef struct packed {
      logic [7:0] length;
      logic [2:0] code_rate;
      logic       crc_on;
      logic [3:0] check;
   } header_t;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_HDR_LO,
      TX_HDR_HI,
      TX_PAYLOAD
   } tx_state_t;

   function automatic logic [3:0] header_check(input logic [7:0] length,
                                                input logic [2:0] code_rate,
                                                input logic       crc_on);
      header_check = length[7:4] ^ length[3:0] ^ {code_rate, crc_on};
   endfunction : header_check

endpackage : modem_params_pkg

// ==== design/sym_buffer.sv ====
`timescale 1ns/100ps
`default_nettype none
module sym_buffer (
   input  wire logic                        clk_sys,
   input  wire logic                        reset_n,
   input  wire logic                        in_valid,
   output logic                             in_ready,
   input  wire modem_params_pkg::sym_word_t in_data,
   output logic                             out_valid,
   input  wire logic                        out_ready,
   output modem_params_pkg::sym_word_t      out_data
);

   // ********************************************************************
   // Two-entry buffer state.
   // ********************************************************************
   typedef struct packed {
      modem_params_pkg::sym_word_t [1:0] mem;
      logic                              wr_ptr;
      logic                              rd_ptr;
      logic [1:0]                        count;
   } buf_state_t;

   buf_state_t state_reg;
   buf_state_t state_next;
   logic       push;
   logic       pop;

   assign in_ready  = (state_reg.count != 2'h2);
   assign out_valid = (state_reg.count != 2'h0);
   assign out_data  = state_reg.mem[state_reg.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      state_next = state_reg;
      if (push) begin
         state_next.mem[state_reg.wr_ptr] = in_data;
         state_next.wr_ptr = ~state_reg.wr_ptr;
      end
      if (pop) begin
         state_next.rd_ptr = ~state_reg.rd_ptr;
      end
      if (push && !pop) begin
         state_next.count = state_reg.count + 2'h1;
      end else if (pop && !push) begin
         state_next.count = state_reg.count - 2'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule : sym_buffer
`default_nettype wire

// ==== design/spread_modem_params.sv ====
`timescale 1ns/100ps
`default_nettype none
module spread_modem_params #(
   parameter logic [12:0] CHIP_CYCLES_BW0 = modem_params_pkg::CHIP_CYC_0,
   parameter logic [12:0] CHIP_CYCLES_BW1 = modem_params_pkg::CHIP_CYC_1
) (
   input  wire logic                         clk_sys,
   input  wire logic                         reset_n,
   input  wire logic                         sleep_mode,
   input  wire logic                         mode_write,
   input  wire logic                         mode_spread_req,
   output logic                              map_select,
   output logic                              mode_change_refused,
   input  wire logic                         cfg_write,
   input  wire modem_params_pkg::modem_cfg_t cfg_in,
   input  wire logic                         low_band,
   output modem_params_pkg::modem_cfg_t      cfg_active,
   output logic                              cfg_valid,
   output logic                              sf6_setup_error,
   output logic [12:0]                       chips_per_symbol,
   output logic [3:0]                        overhead_quarters,
   output logic [18:0]                       channel_width_hz,
   output logic                              symbol_tick,
   input  wire logic [7:0]                   tx_payload_len,
   input  wire logic                         s_valid,
   output logic                              s_ready,
   input  wire logic [7:0]                   s_data,
   input  wire logic                         s_last,
   output logic                              m_valid,
   input  wire logic                         m_ready,
   output modem_params_pkg::sym_word_t       m_data,
   input  wire logic                         rx_hdr_valid,
   input  wire modem_params_pkg::header_t    rx_hdr,
   output logic                              rx_hdr_ok,
   output logic                              rx_hdr_drop,
   output logic [2:0]                        rx_code_rate
);

   // ********************************************************************
   // State.
   // ********************************************************************
   typedef struct packed {
      logic                         spread_mode;
      logic                         refused;
      modem_params_pkg::modem_cfg_t cfg;
      logic                         cfg_ok;
      logic                         sf6_err;
      modem_params_pkg::tx_state_t  tx;
      logic [12:0]                  chip_cnt;
      logic [12:0]                  sym_cnt;
      logic                         sym_tick;
      logic [2:0]                   rx_cr;
      logic                         hdr_ok;
      logic                         hdr_drop;
   } top_state_t;

   top_state_t                  state_reg;
   top_state_t                  state_next;
   logic                        buf_in_valid;
   logic                        buf_in_ready;
   modem_params_pkg::sym_word_t buf_in_data;
   modem_params_pkg::header_t   tx_hdr;
   logic [12:0]                 chip_cycles;
   logic [12:0]                 sym_chips;
   logic [18:0]                 bw_hz;
   logic                        sf_ok;
   logic                        cr_ok;
   logic                        bw_ok;
   logic                        tx_enable;

   // ********************************************************************
   // Decoding of the active settings.
   // ********************************************************************
   always_comb begin
      case (state_reg.cfg.bandwidth_code)
         4'h0: begin
            chip_cycles = CHIP_CYCLES_BW0;
            bw_hz = 19'(modem_params_pkg::BW0_HZ);
         end
         4'h1: begin
            chip_cycles = CHIP_CYCLES_BW1;
            bw_hz = 19'(modem_params_pkg::BW1_HZ);
         end
         4'h2: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_2;
            bw_hz = 19'(modem_params_pkg::BW2_HZ);
         end
         4'h3: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_3;
            bw_hz = 19'(modem_params_pkg::BW3_HZ);
         end
         4'h4: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_4;
            bw_hz = 19'(modem_params_pkg::BW4_HZ);
         end
         4'h5: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_5;
            bw_hz = 19'(modem_params_pkg::BW5_HZ);
         end
         4'h6: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_6;
            bw_hz = 19'(modem_params_pkg::BW6_HZ);
         end
         4'h7: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_7;
            bw_hz = 19'(modem_params_pkg::BW7_HZ);
         end
         4'h8: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_8;
            bw_hz = 19'(modem_params_pkg::BW8_HZ);
         end
         4'h9: begin
            chip_cycles = modem_params_pkg::CHIP_CYC_9;
            bw_hz = 19'(modem_params_pkg::BW9_HZ);
         end
         default: begin
            chip_cycles = 13'h0001;
            bw_hz = 19'h00000;
         end
      endcase
   end

   assign sf_ok = (state_reg.cfg.spread_factor_value >= modem_params_pkg::SF_MIN) &&
                  (state_reg.cfg.spread_factor_value <= modem_params_pkg::SF_MAX);
   assign cr_ok = (state_reg.cfg.cyclic_code_select >= modem_params_pkg::CR_MIN) &&
                  (state_reg.cfg.cyclic_code_select <= modem_params_pkg::CR_MAX);
   assign bw_ok = (state_reg.cfg.bandwidth_code <= modem_params_pkg::BW_CODE_MAX) &&
                  (!low_band ||
                   state_reg.cfg.bandwidth_code <= modem_params_pkg::BW_LOW_BAND_MAX);
   assign sym_chips = 13'h0001 << state_reg.cfg.spread_factor_value;
   assign tx_enable = state_reg.spread_mode && state_reg.cfg_ok;

   always_comb begin
      tx_hdr.length    = tx_payload_len;
      tx_hdr.code_rate = state_reg.cfg.cyclic_code_select;
      tx_hdr.crc_on    = state_reg.cfg.crc_on;
      tx_hdr.check     = modem_params_pkg::header_check(tx_payload_len,
                                                        state_reg.cfg.cyclic_code_select,
                                                        state_reg.cfg.crc_on);
   end

   // ********************************************************************
   // Next-state logic.
   // ********************************************************************
   always_comb begin
      state_next = state_reg;
      state_next.refused = 1'b0;
      state_next.sym_tick = 1'b0;
      state_next.hdr_ok = 1'b0;
      state_next.hdr_drop = 1'b0;
      buf_in_valid = 1'b0;
      buf_in_data = '0;
      s_ready = 1'b0;

      if (mode_write) begin
         if (sleep_mode) begin
            state_next.spread_mode = mode_spread_req;
         end else begin
            state_next.refused = 1'b1;
         end
      end
      if (cfg_write) begin
         state_next.cfg = cfg_in;
      end
      state_next.cfg_ok = sf_ok && cr_ok && bw_ok;
      state_next.sf6_err = (state_reg.cfg.spread_factor_value == modem_params_pkg::SF_HIGH_RATE) &&
         (!state_reg.cfg.implicit_header ||
          state_reg.cfg.detect_tuning_field != modem_params_pkg::SF6_DETECT_TUNE ||
          state_reg.cfg.detect_threshold != modem_params_pkg::SF6_THRESHOLD);

      if (tx_enable) begin
         if (state_reg.chip_cnt >= chip_cycles - 13'h0001) begin
            state_next.chip_cnt = 13'h0000;
            if (state_reg.sym_cnt >= sym_chips - 13'h0001) begin
               state_next.sym_cnt = 13'h0000;
               state_next.sym_tick = 1'b1;
            end else begin
               state_next.sym_cnt = state_reg.sym_cnt + 13'h0001;
            end
         end else begin
            state_next.chip_cnt = state_reg.chip_cnt + 13'h0001;
         end
      end else begin
         state_next.chip_cnt = 13'h0000;
         state_next.sym_cnt = 13'h0000;
      end

      case (state_reg.tx)
         modem_params_pkg::TX_IDLE: begin
            if (tx_enable && s_valid) begin
               if (state_reg.cfg.implicit_header) begin
                  state_next.tx = modem_params_pkg::TX_PAYLOAD;
               end else begin
                  state_next.tx = modem_params_pkg::TX_HDR_LO;
               end
            end
         end
         modem_params_pkg::TX_HDR_LO: begin
            buf_in_valid = 1'b1;
            buf_in_data = {tx_hdr[7:0], modem_params_pkg::CR_HEADER, 1'b1};
            if (buf_in_ready) begin
               state_next.tx = modem_params_pkg::TX_HDR_HI;
            end
         end
         modem_params_pkg::TX_HDR_HI: begin
            buf_in_valid = 1'b1;
            buf_in_data = {tx_hdr[15:8], modem_params_pkg::CR_HEADER, 1'b1};
            if (buf_in_ready) begin
               state_next.tx = modem_params_pkg::TX_PAYLOAD;
            end
         end
         modem_params_pkg::TX_PAYLOAD: begin
            buf_in_valid = s_valid;
            s_ready = buf_in_ready;
            buf_in_data = {s_data, state_reg.cfg.cyclic_code_select, 1'b0};
            if (s_valid && buf_in_ready && s_last) begin
               state_next.tx = modem_params_pkg::TX_IDLE;
            end
         end
         default: begin
            state_next.tx = modem_params_pkg::TX_IDLE;
         end
      endcase

      if (rx_hdr_valid) begin
         if (rx_hdr.check == modem_params_pkg::header_check(rx_hdr.length, rx_hdr.code_rate,
                                                            rx_hdr.crc_on) &&
             rx_hdr.code_rate >= modem_params_pkg::CR_MIN &&
             rx_hdr.code_rate <= modem_params_pkg::CR_MAX) begin
            state_next.rx_cr = rx_hdr.code_rate;
            state_next.hdr_ok = 1'b1;
         end else begin
            state_next.hdr_drop = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.cfg.spread_factor_value <= modem_params_pkg::RESET_SF;
         state_reg.cfg.cyclic_code_select <= modem_params_pkg::RESET_CR;
         state_reg.cfg.bandwidth_code <= modem_params_pkg::RESET_BW;
         state_reg.cfg.detect_tuning_field <= modem_params_pkg::RESET_DETECT;
         state_reg.cfg.detect_threshold <= modem_params_pkg::RESET_THRESHOLD;
         state_reg.rx_cr <= modem_params_pkg::RESET_CR;
         state_reg.tx <= modem_params_pkg::TX_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ********************************************************************
   // Output buffer.
   // ********************************************************************
   sym_buffer u_sym_buffer (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (m_valid),
      .out_ready (m_ready),
      .out_data  (m_data)
   );

   // ********************************************************************
   // Outputs.
   // ********************************************************************
   assign map_select = state_reg.spread_mode;
   assign mode_change_refused = state_reg.refused;
   assign cfg_active = state_reg.cfg;
   assign cfg_valid = state_reg.cfg_ok;
   assign sf6_setup_error = state_reg.sf6_err;
   assign chips_per_symbol = sym_chips;
   assign overhead_quarters = modem_params_pkg::OVERHEAD_BASE +
                              {1'b0, state_reg.cfg.cyclic_code_select};
   assign channel_width_hz = bw_hz;
   assign symbol_tick = state_reg.sym_tick;
   assign rx_hdr_ok = state_reg.hdr_ok;
   assign rx_hdr_drop = state_reg.hdr_drop;
   assign rx_code_rate = state_reg.rx_cr;

endmodule : spread_modem_params
`default_nettype wire

// ==== test/modem_params_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module modem_params_props (
   input wire logic                         clk_sys,
   input wire logic                         reset_n,
   input wire logic                         sleep_mode,
   input wire logic                         mode_write,
   input wire logic                         mode_spread_req,
   input wire logic                         map_select,
   input wire logic                         mode_change_refused,
   input wire logic                         low_band,
   input wire modem_params_pkg::modem_cfg_t cfg_active,
   input wire logic                         cfg_valid,
   input wire logic                         sf6_setup_error,
   input wire logic [12:0]                  chips_per_symbol,
   input wire logic [3:0]                   overhead_quarters,
   input wire logic                         m_valid,
   input wire logic                         m_ready,
   input wire modem_params_pkg::sym_word_t  m_data,
   input wire logic                         rx_hdr_valid,
   input wire modem_params_pkg::header_t    rx_hdr,
   input wire logic                         rx_hdr_ok,
   input wire logic                         rx_hdr_drop,
   input wire logic [2:0]                   rx_code_rate
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire modem_params_pkg::modem_cfg_t c = cfg_active;
   wire logic [3:0] hc = rx_hdr.length[7:4] ^ rx_hdr.length[3:0] ^ {rx_hdr.code_rate, rx_hdr.crc_on};
   sequence mode_req_s(s);
      mode_write && (sleep_mode == s);
   endsequence
   mode_refuse_a: assert property (mode_req_s(1'b0) |=>
      mode_change_refused && $stable(map_select))
      else $error("mode change not refused");
   mode_take_a: assert property (mode_req_s(1'b1) |=>
      map_select == $past(mode_spread_req))
      else $error("mode change not taken");
   chip_count_a: assert property (c.spread_factor_value inside {[6:12]} |->
      chips_per_symbol == (13'h1 << c.spread_factor_value))
      else $error("chip count wrong");
   code_overhead_a: assert property (c.cyclic_code_select inside {[1:4]} |->
      overhead_quarters == 4'h4 + {1'b0, c.cyclic_code_select})
      else $error("overhead wrong");
   low_band_a: assert property ($past(low_band) && $stable(c) &&
      c.bandwidth_code >= 4'h8 |-> !cfg_valid)
      else $error("low band width accepted");
   bad_field_a: assert property ($stable(c) &&
      (!(c.spread_factor_value inside {[6:12]}) || !(c.cyclic_code_select inside {[1:4]})) |->
      !cfg_valid)
      else $error("bad field accepted");
   sf6_flag_a: assert property ($stable(c) && c.spread_factor_value == 4'h6 &&
      !c.implicit_header |-> sf6_setup_error)
      else $error("sf6 setup not flagged");
   header_rate_a: assert property (m_valid && m_data.is_header |->
      m_data.code_rate == 3'h4)
      else $error("header rate wrong");
   word_hold_a: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data))
      else $error("word lost in stall");
   header_drop_a: assert property (rx_hdr_valid && rx_hdr.check != hc |=>
      rx_hdr_drop && !rx_hdr_ok)
      else $error("bad header kept");
   rate_take_a: assert property (rx_hdr_ok |->
      rx_code_rate == $past(rx_hdr.code_rate))
      else $error("rate not taken");
endmodule : modem_params_props
`default_nettype wire

// ==== test/stream_sink.sv ====
`timescale 1ns/100ps
`default_nettype none
module stream_sink (
   input  wire logic                        clk_sys,
   input  wire logic                        stall,
   input  wire logic                        m_valid,
   output logic                             m_ready,
   input  wire modem_params_pkg::sym_word_t m_data
);
   modem_params_pkg::sym_word_t got [0:7];
   int                          n  = 0;
   logic [1:0]                  ph = 2'h0;
   // When stalling, ready is offered two cycles out of four.
   always @(posedge clk_sys) begin
      ph <= ph + 2'h1;
      m_ready <= !stall || ph[1];
      if (m_valid && m_ready) begin
         got[n[2:0]] <= m_data;
         n <= n + 1;
      end
   end
endmodule : stream_sink
`default_nettype wire

// ==== test/tb_spread_modem_params.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_spread_modem_params;
   logic clk_sys = 1'b0, reset_n = 1'b0, sleep_mode = 1'b1, mode_write = 1'b0;
   logic mode_spread_req = 1'b0, cfg_write = 1'b0, low_band = 1'b0, stall = 1'b1;
   logic s_valid = 1'b0, s_last = 1'b0, rx_hdr_valid = 1'b0;
   logic [7:0] tx_payload_len = 8'h02, s_data = 8'h00;
   modem_params_pkg::modem_cfg_t cfg_in = '0, cfg_active;
   modem_params_pkg::header_t rx_hdr = '0;
   modem_params_pkg::sym_word_t m_data;
   logic map_select, mode_change_refused, cfg_valid, sf6_setup_error, symbol_tick, s_ready;
   logic m_valid, m_ready, rx_hdr_ok, rx_hdr_drop;
   logic [12:0] chips_per_symbol;
   logic [3:0] overhead_quarters;
   logic [18:0] channel_width_hz;
   logic [2:0] rx_code_rate;
   int num_errors = 0, total_checks = 0;
   int bw_hz [10] = '{7800, 10400, 15600, 20800, 31200, 41700, 62500, 125000, 250000, 500000};
   spread_modem_params #(.CHIP_CYCLES_BW0(13'h4), .CHIP_CYCLES_BW1(13'h4)) u_spread_modem_params (
      .clk_sys, .reset_n, .sleep_mode, .mode_write, .mode_spread_req, .map_select,
      .mode_change_refused, .cfg_write, .cfg_in, .low_band, .cfg_active, .cfg_valid,
      .sf6_setup_error, .chips_per_symbol, .overhead_quarters, .channel_width_hz, .symbol_tick,
      .tx_payload_len, .s_valid, .s_ready, .s_data, .s_last, .m_valid, .m_ready, .m_data,
      .rx_hdr_valid, .rx_hdr, .rx_hdr_ok, .rx_hdr_drop, .rx_code_rate);
   stream_sink u_stream_sink (.clk_sys, .stall, .m_valid, .m_ready, .m_data);
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic expire(string what);
      chk(what, 0, 1);
      close_out();
   endtask : expire
   task automatic mode(input logic slp, input logic req);
      @(posedge clk_sys);
      sleep_mode <= slp;
      mode_write <= 1'b1;
      mode_spread_req <= req;
      @(posedge clk_sys);
      mode_write <= 1'b0;
      @(negedge clk_sys);
      chk("refused", mode_change_refused, !slp);
      if (slp) chk("map", map_select, req);
   endtask : mode
   task automatic set_cfg(input logic [3:0] sf, input logic [2:0] cr, input logic [3:0] bw,
                          input logic imp, input logic [2:0] tn, input logic [7:0] th);
      @(posedge clk_sys);
      cfg_in <= '{sf, cr, bw, imp, 1'b1, tn, th};
      cfg_write <= 1'b1;
      @(posedge clk_sys);
      cfg_write <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : set_cfg
   task automatic t_cfg();
      for (int sf = 6; sf <= 12; sf++) begin
         set_cfg(sf, 1 + sf % 4, 7, 1, sf == 6 ? 5 : 3, sf == 6 ? 8'h0c : 8'h0a);
         chk("chips", chips_per_symbol, 1 << sf);
         chk("overhead", overhead_quarters, 5 + sf % 4);
         chk("valid", cfg_valid, 1);
      end
      for (int b = 0; b < 10; b++) begin
         set_cfg(7, 1, b, 0, 3, 8'h0a);
         chk("width", channel_width_hz, bw_hz[b]);
      end
      @(posedge clk_sys) low_band <= 1'b1;
      set_cfg(7, 1, 8, 0, 3, 8'h0a);
      chk("low band 250", cfg_valid, 0);
      set_cfg(7, 1, 6, 0, 3, 8'h0a);
      chk("low band 62.5", cfg_valid, 1);
      @(posedge clk_sys) low_band <= 1'b0;
      set_cfg(13, 1, 7, 0, 3, 8'h0a);
      chk("sf 13", cfg_valid, 0);
      set_cfg(5, 1, 7, 0, 3, 8'h0a);
      chk("sf 5", cfg_valid, 0);
      set_cfg(7, 0, 7, 0, 3, 8'h0a);
      chk("cr 0", cfg_valid, 0);
   endtask : t_cfg
   task automatic t_sf6();
      int n;
      set_cfg(6, 1, 0, 0, 5, 8'h0c);
      chk("sf6 explicit", sf6_setup_error, 1);
      set_cfg(6, 1, 0, 1, 3, 8'h0c);
      chk("sf6 tuning", sf6_setup_error, 1);
      set_cfg(6, 1, 0, 1, 5, 8'h0a);
      chk("sf6 thresh", sf6_setup_error, 1);
      set_cfg(7, 1, 7, 0, 3, 8'h0a);
      chk("sf7 defaults", sf6_setup_error, 0);
      set_cfg(6, 1, 0, 1, 5, 8'h0c);
      chk("sf6 ready", sf6_setup_error, 0);
      n = 0;
      while (symbol_tick !== 1'b1 && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 1000) expire("tick wait");
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (symbol_tick !== 1'b1 && n < 1000);
      chk("symbol period", n, 256);
   endtask : t_sf6
   task automatic send(input logic [7:0] d, input logic l);
      int n;
      @(posedge clk_sys);
      s_valid <= 1'b1;
      s_data <= d;
      s_last <= l;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (s_ready !== 1'b1 && n < 100);
      if (n >= 100) expire("send wait");
      @(posedge clk_sys);
      s_valid <= 1'b0;
   endtask : send
   task automatic t_tx();
      int n;
      set_cfg(7, 2, 7, 0, 3, 8'h0a);
      send(8'ha5, 1'b0);
      send(8'h3c, 1'b1);
      for (n = 0; u_stream_sink.n < 4 && n < 200; n++) @(negedge clk_sys);
      if (n >= 200) expire("sink wait");
      chk("hdr low", u_stream_sink.got[0], {3'h2, 1'b1, 4'h7, 3'h4, 1'b1});
      chk("hdr high", u_stream_sink.got[1], {8'h02, 3'h4, 1'b1});
      chk("byte 0", u_stream_sink.got[2], {8'ha5, 3'h2, 1'b0});
      chk("byte 1", u_stream_sink.got[3], {8'h3c, 3'h2, 1'b0});
   endtask : t_tx
   task automatic rx(input modem_params_pkg::header_t h, input logic ok);
      @(posedge clk_sys);
      rx_hdr <= h;
      rx_hdr_valid <= 1'b1;
      @(posedge clk_sys);
      rx_hdr_valid <= 1'b0;
      @(negedge clk_sys);
      chk("hdr ok", rx_hdr_ok, ok);
      chk("hdr drop", rx_hdr_drop, !ok);
      chk("rx rate", rx_code_rate, 3'h3);
   endtask : rx
   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("reset map", map_select, 0);
      chk("reset cfg", cfg_active.spread_factor_value, 7);
      chk("reset valid", cfg_valid, 1);
      chk("reset rate", rx_code_rate, 1);
      mode(1'b0, 1'b1);
      mode(1'b1, 1'b1);
      mode(1'b1, 1'b0);
      mode(1'b1, 1'b1);
      t_cfg();
      t_sf6();
      t_tx();
      rx('{8'h35, 3'h3, 1'b0, 4'h3 ^ 4'h5 ^ 4'h6}, 1'b1);
      rx('{8'h35, 3'h2, 1'b0, 4'h0}, 1'b0);
      rx('{8'h35, 3'h0, 1'b0, 4'h3 ^ 4'h5}, 1'b0);
      close_out();
   end
endmodule : tb_spread_modem_params
bind spread_modem_params modem_params_props u_modem_params_props (
   .clk_sys, .reset_n, .sleep_mode, .mode_write, .mode_spread_req, .map_select,
   .mode_change_refused, .low_band, .cfg_active, .cfg_valid, .sf6_setup_error,
   .chips_per_symbol, .overhead_quarters, .m_valid, .m_ready, .m_data, .rx_hdr_valid,
   .rx_hdr, .rx_hdr_ok, .rx_hdr_drop, .rx_code_rate);
`default_nettype wire
